// ### pkg/gfes_regs.svh
// Register map, reset values and timing figures of the gate fault/enable sequencer.
// Assumes a 25 MHz APB clock; the design takes its numbers from here, the package and the bench do not.
`ifndef GFES_REGS_SVH
`define GFES_REGS_SVH

// ----------------------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------------------
`define GFES_IDX_STATUS1    4'h0
`define GFES_IDX_STATUS2    4'h1
`define GFES_IDX_CTRL1      4'h2
`define GFES_IDX_CTRL2      4'h3
`define GFES_ADDR_SHIFT     2

// ----------------------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------------------
`define GFES_DATA_W         11
`define GFES_CTRL1_RST      11'h000
`define GFES_CTRL2_RST      11'h000
`define GFES_ST2_ID_W       4

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define GFES_CLK_MHZ        25
`define GFES_QUICK_US       10
`define GFES_FULL_US        20
`define GFES_OC_PULSE_US    64
`define GFES_QUICK_CYC      (`GFES_QUICK_US * `GFES_CLK_MHZ)
`define GFES_FULL_CYC       (`GFES_FULL_US * `GFES_CLK_MHZ)
`define GFES_OC_PULSE_CYC   (`GFES_OC_PULSE_US * `GFES_CLK_MHZ)

`endif

// ### pkg/gfes_pkg.sv
// Types shared by the gate fault/enable sequencer and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package gfes_pkg;

  // --------------------------------------------------------------------------
  // Enable sequencing states
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_RUN   = 4'h2,
    ST_LOW   = 4'h4,
    ST_SLEEP = 4'h8
  } gfes_state_t;

  typedef enum logic [1:0] {
    OCP_CLIMIT  = 2'h0,
    OCP_LATCH   = 2'h1,
    OCP_REPORT  = 2'h2,
    OCP_DISABLE = 2'h3
  } gfes_ocp_t;

  typedef enum logic [1:0] {
    WSEL_BOTH   = 2'h0,
    WSEL_OT     = 2'h1,
    WSEL_OC     = 2'h2,
    WSEL_OC_ALT = 2'h3
  } gfes_wsel_t;

  // --------------------------------------------------------------------------
  // Control registers and monitor inputs
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [4:0] oc_adj;
    gfes_ocp_t  ocp_mode;
    logic       pwm_mode;
    logic       gate_reset;
    logic [1:0] gate_current;
  } gfes_ctrl1_t;

  typedef struct packed {
    logic [3:0] rsvd;
    logic       oc_toff;
    logic       dc_cal2;
    logic       dc_cal1;
    logic [1:0] gain;
    gfes_wsel_t warning_select_field;
  } gfes_ctrl2_t;

  typedef struct packed {
    logic power_supply_undervoltage;
    logic gate_supply_undervoltage;
    logic gate_supply_overvoltage;
    logic logic_supply_undervoltage;
    logic overtemp_warning;
    logic overtemp_driver_shutdown;
  } gfes_mon_t;

endpackage

// ### design/gfes_top.sv
// Fault supervision and gate-enable sequencing for a three-phase gate driver.
// Assumes comparator and enable inputs already synchronous to pclk; fet vectors
// are ordered high A, low A, high B, low B, high C, low C from bit 5 down.
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`include "gfes_regs.svh"

module gfes_top #(
  parameter int              ADDR_W    = 8,
  parameter logic [3:0]      DEVICE_ID = 4'h5,  // Arbitrary value.
  parameter int              CNT_W     = 10,
  parameter int              TMR_W     = 11
) (
  input  wire logic                  pclk,               // APB clock, 25 MHz
  input  wire logic                  presetn,            // Async reset, active low
  input  wire logic                  psel,               // APB select
  input  wire logic                  penable,            // APB enable
  input  wire logic                  pwrite,             // APB direction
  input  wire logic [ADDR_W-1:0]     paddr,              // APB byte address
  input  wire logic [31:0]           pwdata,             // APB write data
  output logic      [31:0]           prdata,             // APB read data
  output logic                       pready,             // APB ready
  output logic                       pslverr,            // APB error
  input  wire logic                  gate_enable_in,     // Gate enable pin level
  input  wire gfes_pkg::gfes_mon_t   mon,                // Supply and temperature monitors
  input  wire logic [5:0]            oc_detect,          // Per-fet overcurrent comparators
  input  wire logic [5:0]            pwm_in,             // PWM inputs, fet order
  output logic      [5:0]            gate_out,           // Gate outputs, fet order
  output logic                       weak_pulldown,      // Weak pulldown on all gates
  output logic                       charge_pump_en,     // Charge pump enable
  output logic                       aux_blocks_en,      // Amplifiers and regulator enable
  output gfes_pkg::gfes_ctrl1_t      ctrl1_out,          // Gate drive settings
  output gfes_pkg::gfes_ctrl2_t      ctrl2_out,          // Amplifier settings
  input  wire logic                  fault_n_output_i,   // Fault pin level
  output logic                       fault_n_output_o,   // Fault pin drive value
  output logic                       fault_n_output_oe,  // Fault pin pulls low
  input  wire logic                  warning_n_output_i, // Warning pin level
  output logic                       warning_n_output_o, // Warning pin drive value
  output logic                       warning_n_output_oe // Warning pin pulls low
);
  import gfes_pkg::*;

  localparam logic [CNT_W-1:0] QUICK_CYC = CNT_W'(`GFES_QUICK_CYC);
  localparam logic [CNT_W-1:0] FULL_CYC  = CNT_W'(`GFES_FULL_CYC);
  localparam logic [TMR_W-1:0] OC_CYC    = TMR_W'(`GFES_OC_PULSE_CYC);

  function automatic logic [3:0] reg_index(input logic [ADDR_W-1:0] a);
    reg_index = a[`GFES_ADDR_SHIFT +: 4];
  endfunction

  // --------------------------------------------------------------------------
  // Enable sequencing
  // --------------------------------------------------------------------------
  gfes_state_t       state_r;
  gfes_state_t       state_nxt;
  logic [CNT_W-1:0]  low_cnt_r;
  logic              en_d_r;
  logic              rise_evt;
  logic              full_rst;
  logic              low_power;

  assign rise_evt  = gate_enable_in & ~en_d_r;
  assign low_power = (state_r == ST_IDLE) | (state_r == ST_SLEEP);
  // full reset after low beyond 20 us
  assign full_rst  = (state_r == ST_SLEEP) & ~gate_enable_in & (low_cnt_r == FULL_CYC);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_d_r <= 1'b0;
    end else begin
      en_d_r <= gate_enable_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt_r <= '0;
    end else if (gate_enable_in) begin
      low_cnt_r <= '0;
    end else if (low_cnt_r != FULL_CYC) begin
      low_cnt_r <= low_cnt_r + CNT_W'(1);
    end
  end

  // A rise from the 10..20 us band is treated like a quick reset; the
  // controller must not produce that band, so nothing better is defined.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        // start only on an enable rise
        if (rise_evt) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!gate_enable_in) begin
          state_nxt = ST_LOW;
        end
      end
      ST_LOW: begin
        // short low keeps other blocks alive
        if (gate_enable_in) begin
          state_nxt = ST_RUN;
        end else if (low_cnt_r == QUICK_CYC) begin
          state_nxt = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (gate_enable_in) begin
          state_nxt = ST_RUN;
        end else if (full_rst) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // APB registers
  // --------------------------------------------------------------------------
  gfes_ctrl1_t ctrl1_r;
  gfes_ctrl2_t ctrl2_r;
  gfes_ctrl1_t wr_ctrl1;
  logic [3:0]  idx;
  logic        mapped;
  logic        refused;
  logic        access;
  logic        wr_ok;
  logic        spi_rst;
  logic        reg_dflt;
  logic [31:0] rd_nxt;
  logic [`GFES_DATA_W-1:0] status1;
  logic [`GFES_DATA_W-1:0] status2;

  assign idx      = reg_index(paddr);
  assign mapped   = (paddr[`GFES_ADDR_SHIFT-1:0] == '0) &
                    (paddr[ADDR_W-1:`GFES_ADDR_SHIFT] <= (ADDR_W-`GFES_ADDR_SHIFT)'(`GFES_IDX_CTRL2));
  // serial refused in power supply undervoltage or low power
  assign refused  = mon.power_supply_undervoltage | low_power;
  assign access   = psel & penable;
  assign pready   = access;
  assign pslverr  = access & (refused | ~mapped |
                    (pwrite & (idx != `GFES_IDX_CTRL1) & (idx != `GFES_IDX_CTRL2)));
  assign wr_ok    = access & pwrite & ~pslverr;
  // gate reset command pulse, never stored
  assign wr_ctrl1 = gfes_ctrl1_t'(pwdata[`GFES_DATA_W-1:0]);
  assign spi_rst  = wr_ctrl1.gate_reset & wr_ok & (idx == `GFES_IDX_CTRL1);
  // defaults on power undervoltage or full reset
  assign reg_dflt = mon.power_supply_undervoltage | full_rst;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_r <= gfes_ctrl1_t'(`GFES_CTRL1_RST);
    end else if (reg_dflt) begin
      ctrl1_r <= gfes_ctrl1_t'(`GFES_CTRL1_RST);
    end else if (wr_ok && idx == `GFES_IDX_CTRL1) begin
      ctrl1_r            <= gfes_ctrl1_t'(pwdata[`GFES_DATA_W-1:0]);
      ctrl1_r.gate_reset <= 1'b0;
    end
  end

  // warning select resets to both sources
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl2_r <= gfes_ctrl2_t'(`GFES_CTRL2_RST);
    end else if (reg_dflt) begin
      ctrl2_r <= gfes_ctrl2_t'(`GFES_CTRL2_RST);
    end else if (wr_ok && idx == `GFES_IDX_CTRL2) begin
      ctrl2_r <= gfes_ctrl2_t'(pwdata[`GFES_DATA_W-1:0]);
    end
  end

  // Read data is captured in the setup cycle so it comes from a flip-flop.
  always_comb begin
    rd_nxt = '0;
    if (mapped && !refused) begin
      case (idx)
        `GFES_IDX_STATUS1: rd_nxt[`GFES_DATA_W-1:0] = status1;
        `GFES_IDX_STATUS2: rd_nxt[`GFES_DATA_W-1:0] = status2;
        `GFES_IDX_CTRL1:   rd_nxt[`GFES_DATA_W-1:0] = ctrl1_r;
        `GFES_IDX_CTRL2:   rd_nxt[`GFES_DATA_W-1:0] = ctrl2_r;
        default:           rd_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable) begin
      prdata <= rd_nxt;
    end
  end

  assign ctrl1_out = ctrl1_r;
  assign ctrl2_out = ctrl2_r;

  // --------------------------------------------------------------------------
  // Fault latches
  // --------------------------------------------------------------------------
  logic       gov_r;
  logic       otsd_r;
  logic [2:0] oc_ph_r;
  logic [5:0] oc_st_r;
  logic [5:0] cl_blk_r;
  logic [TMR_W-1:0] oc_tmr_r;
  logic       luv_d_r;
  logic       gd_clr;
  logic       luv_recover;
  logic       oc_act;
  logic       drv_on;
  logic       any_fault;
  logic [5:0] pwm_v;

  assign gd_clr      = rise_evt | spi_rst | full_rst;
  assign luv_recover = luv_d_r & ~mon.logic_supply_undervoltage;
  assign oc_act      = (ctrl1_r.ocp_mode == OCP_CLIMIT) | (ctrl1_r.ocp_mode == OCP_REPORT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      luv_d_r <= 1'b0;
    end else begin
      luv_d_r <= mon.logic_supply_undervoltage;
    end
  end

  // overvoltage cleared only by full reset; set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gov_r <= 1'b0;
    end else if (mon.gate_supply_overvoltage) begin
      gov_r <= 1'b1;
    end else if (full_rst) begin
      gov_r <= 1'b0;
    end
  end

  // cleared only once temperature is below clear level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      otsd_r <= 1'b0;
    end else if (mon.overtemp_driver_shutdown) begin
      otsd_r <= 1'b1;
    end else if (gd_clr) begin
      otsd_r <= 1'b0;
    end
  end

  // latch the phase of the offending fet
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_ph_r <= '0;
    end else begin
      for (int p = 0; p < 3; p++) begin
        if (ctrl1_r.ocp_mode == OCP_LATCH && (oc_detect[2*p] || oc_detect[2*p+1])) begin
          oc_ph_r[p] <= 1'b1;
        end else if (gd_clr) begin
          oc_ph_r[p] <= 1'b0;
        end
      end
    end
  end

  // status bits: set wins over every clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_st_r <= '0;
    end else if (ctrl1_r.ocp_mode != OCP_DISABLE) begin
      oc_st_r <= oc_detect | (oc_st_r & {6{~(gd_clr | luv_recover)}});
    end else begin
      oc_st_r <= oc_st_r & {6{~(gd_clr | luv_recover)}};
    end
  end

  // warning pulse and off-time timer restart on each event in current-limit or report mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_tmr_r <= '0;
    end else if (oc_act && (|oc_detect)) begin
      oc_tmr_r <= OC_CYC;
    end else if (oc_tmr_r != '0) begin
      oc_tmr_r <= oc_tmr_r - TMR_W'(1);
    end
  end

  // block only the offending fet until its next PWM cycle, or until the off-time timer ends if oc_toff is set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cl_blk_r <= '0;
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (ctrl1_r.ocp_mode == OCP_CLIMIT && oc_detect[i]) begin
          cl_blk_r[i] <= 1'b1;
        end else if (!pwm_v[i] || !drv_on || (ctrl2_r.oc_toff && oc_tmr_r == '0)) begin
          cl_blk_r[i] <= 1'b0;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Gate outputs
  // --------------------------------------------------------------------------
  logic [5:0] gate_nxt;

  // driver only in run without faults other than a latched overcurrent
  assign drv_on    = (state_r == ST_RUN) & gate_enable_in & ~mon.power_supply_undervoltage &
                     ~mon.gate_supply_undervoltage & ~mon.logic_supply_undervoltage &
                     ~gov_r & ~otsd_r;
  assign any_fault = mon.power_supply_undervoltage | mon.gate_supply_undervoltage |
                     mon.logic_supply_undervoltage | gov_r | otsd_r | (|oc_ph_r);

  always_comb begin
    pwm_v    = '0;
    gate_nxt = '0;
    for (int p = 0; p < 3; p++) begin
      pwm_v[2*p+1] = pwm_in[2*p+1];
      pwm_v[2*p]   = ctrl1_r.pwm_mode ? ~pwm_in[2*p+1] : pwm_in[2*p];
      gate_nxt[2*p+1] = drv_on & pwm_v[2*p+1] & ~pwm_v[2*p] & ~cl_blk_r[2*p+1] & ~oc_ph_r[p];
      gate_nxt[2*p]   = drv_on & pwm_v[2*p] & ~pwm_v[2*p+1] & ~cl_blk_r[2*p] & ~oc_ph_r[p];
    end
  end

  logic fault_act_r;
  logic warn_act_r;
  logic ot_warn;
  logic oc_warn;
  logic warn_nxt;

  assign ot_warn = mon.overtemp_warning | otsd_r;
  assign oc_warn = (oc_tmr_r != '0) | (|oc_ph_r);

  always_comb begin
    case (ctrl2_r.warning_select_field)
      WSEL_BOTH: warn_nxt = ot_warn | oc_warn;
      WSEL_OT:   warn_nxt = ot_warn;
      default:   warn_nxt = oc_warn;
    endcase
  end

  // aux blocks follow the sequencer; pump also stops on latched overvoltage or temperature shutdown
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_out       <= '0;
      weak_pulldown  <= 1'b1;
      charge_pump_en <= 1'b0;
      aux_blocks_en  <= 1'b0;
      fault_act_r    <= 1'b1;
      warn_act_r     <= 1'b0;
    end else begin
      gate_out       <= gate_nxt;
      weak_pulldown  <= ~drv_on;
      charge_pump_en <= ~low_power & ~gov_r & ~otsd_r;
      aux_blocks_en  <= ~low_power;
      // released only when ready for PWM
      fault_act_r    <= any_fault | (state_r != ST_RUN);
      warn_act_r     <= warn_nxt;
    end
  end

  assign fault_n_output_o    = 1'b0;
  assign fault_n_output_oe   = fault_act_r;
  assign warning_n_output_o  = 1'b0;
  assign warning_n_output_oe = warn_act_r;

  // gate and power undervoltage live in status, not on warning pin
  assign status1 = {any_fault, mon.gate_supply_undervoltage, mon.power_supply_undervoltage,
                    otsd_r, mon.overtemp_warning, oc_st_r};
  assign status2 = {3'h0, gov_r, 3'h0, DEVICE_ID};

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_uv_gates_low: assert property (
    (mon.power_supply_undervoltage || mon.gate_supply_undervoltage) |=> (gate_out == 6'h00))
    else $error("gates not low in supply undervoltage");

  a_uv_defaults: assert property (
    mon.power_supply_undervoltage |=> (ctrl1_r == gfes_ctrl1_t'(`GFES_CTRL1_RST)) &&
                                      (ctrl2_r == gfes_ctrl2_t'(`GFES_CTRL2_RST)))
    else $error("registers not defaulted in undervoltage");

  a_ov_shutdown: assert property (
    mon.gate_supply_overvoltage ##1 !full_rst |=> !charge_pump_en && (gate_out == 6'h00))
    else $error("overvoltage did not shut down");

  a_ov_sticky: assert property (
    (gov_r && !full_rst && !mon.gate_supply_overvoltage && (spi_rst || rise_evt)) |=> gov_r)
    else $error("overvoltage cleared by a quick reset");

  a_otsd_fault: assert property (
    mon.overtemp_driver_shutdown |=> otsd_r ##1 fault_n_output_oe)
    else $error("temperature shutdown not reported");

  a_no_shoot: assert property (
    (gate_out & {gate_out[4:0], 1'b0} & 6'h2A) == 6'h00)
    else $error("high and low side on together");

  a_fall_gates: assert property (
    (state_r == ST_RUN && !gate_enable_in) |=> (gate_out == 6'h00) && aux_blocks_en)
    else $error("enable fall did not stop gates at once");

  a_quick_serial: assert property (
    (state_r == ST_LOW && !mon.power_supply_undervoltage && psel && penable && mapped && !pwrite) |-> !pslverr)
    else $error("serial refused during quick reset");

  a_quick_aux: assert property (
    (state_r == ST_LOW) |-> aux_blocks_en)
    else $error("blocks shut down during quick reset");

  a_full_reset: assert property (
    full_rst |-> $past(!gate_enable_in, 1) ##1 (state_r == ST_IDLE) && !gov_r &&
                 (ctrl1_r == gfes_ctrl1_t'(`GFES_CTRL1_RST)))
    else $error("full reset incomplete");

  a_oc_latch: assert property (
    (ctrl1_r.ocp_mode == OCP_LATCH && oc_detect[5] && !gd_clr) |=> ##1
      (gate_out[5:4] == 2'h0) && fault_n_output_oe)
    else $error("latched overcurrent left phase on");

endmodule

// ### sim/gfes_mcu_model.sv
// Controller model: drives the gate enable pin and the PWM inputs.
// Assumes the bench clock; every pin changes just after a rising edge.
`timescale 1ns/10ps
module gfes_mcu_model (
  input  wire logic       pclk,    // Bench clock
  output logic            gate_en, // Gate enable pin
  output logic [5:0]      pwm      // PWM inputs, fet order
);
  initial begin
    gate_en = 1'b0;
    pwm     = 6'h00;
  end
  task automatic set(input logic e, input logic [5:0] p);
    gate_en <= e;
    pwm     <= p;
    @(posedge pclk);
  endtask
  // pulse length
  // Callers keep n out of the 250 to 500 cycle band, which the device treats like a quick reset.
  task automatic low_pulse(input int n);
    gate_en <= 1'b0;
    repeat (n) @(posedge pclk);
    gate_en <= 1'b1;
    @(posedge pclk);
  endtask
endmodule

// ### sim/gate_fault_enable_sequencer_test.sv
// Self-checking bench for the gate fault/enable sequencer.
// Assumes the controller model beside it and an APB master made of tasks here.
`timescale 1ns/10ps
module gate_fault_enable_sequencer_test;
  import gfes_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [5:0] gate_out, pwm;
  logic ge, wpd, cpe, aux, f_oe, w_oe, f_o, w_o;
  logic [5:0] oc = 6'h00;
  gfes_ctrl1_t c1;
  gfes_ctrl2_t c2;
  gfes_mon_t mon = '0;
  int miscompares = 0, checks_done = 0, cyc = 0;
  always #20 pclk = ~pclk;
  gfes_mcu_model u_mcu (.pclk(pclk), .gate_en(ge), .pwm(pwm));
  gfes_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gate_enable_in(ge), .mon(mon), .oc_detect(oc), .pwm_in(pwm), .gate_out(gate_out),
    .weak_pulldown(wpd), .charge_pump_en(cpe), .aux_blocks_en(aux), .ctrl1_out(c1), .ctrl2_out(c2),
    .fault_n_output_i(~f_oe), .fault_n_output_o(f_o), .fault_n_output_oe(f_oe),
    .warning_n_output_i(~w_oe), .warning_n_output_o(w_o), .warning_n_output_oe(w_oe));
  task automatic finish_test();
    if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 5000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask
  // Request is held until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic t_reset();
    chk("gate", 0, gate_out);
    chk("pulldown", 1, wpd);
    chk("fault", 1, f_oe);
    chk("pin drive", 0, {f_o, w_o});
    apb(0, 8'h08, 0);
    chk("refused", 1, err);
  endtask
  task automatic t_start();
    u_mcu.set(1, 6'h24);
    repeat (3) @(posedge pclk);
    chk("gate", 6'h24, gate_out);
    chk("fault", 0, f_oe);
    chk("pump", 1, cpe);
    u_mcu.set(1, 6'h30);
    repeat (3) @(posedge pclk);
    chk("xcond", 0, &gate_out[5:4]);
    apb(0, 8'h0C, 0);
    chk("ctrl2 rst", 0, rd);
    apb(1, 8'h0C, WSEL_OT);
    chk("ctrl2 out", WSEL_OT, c2);
    apb(1, 8'h00, 1);
    chk("st wr", 1, err);
  endtask
  task automatic t_faults();
    mon.gate_supply_undervoltage <= 1;
    repeat (3) @(posedge pclk);
    chk("uv gate", 0, gate_out);
    chk("uv warn", 0, w_oe);
    chk("uv fault", 1, f_oe);
    chk("uv pulldown", 1, wpd);
    mon <= '0;
    repeat (3) @(posedge pclk);
    chk("uv gone", 0, f_oe);
    mon.overtemp_warning <= 1;
    repeat (3) @(posedge pclk);
    chk("ot warn", 1, w_oe);
    chk("ot fault", 0, f_oe);
    mon <= gfes_mon_t'(6'h01);
    @(posedge pclk);
    mon <= '0;
    repeat (3) @(posedge pclk);
    chk("otsd", 1, f_oe);
    apb(0, 8'h0C, 0);
    chk("otsd regs", WSEL_OT, rd);
    apb(1, 8'h08, 32'h4);
    apb(0, 8'h08, 0);
    chk("grst bit", 0, rd);
    chk("otsd clr", 0, f_oe);
  endtask
  task automatic t_ov();
    mon.gate_supply_overvoltage <= 1;
    @(posedge pclk);
    mon <= '0;
    repeat (3) @(posedge pclk);
    chk("ov", 1, f_oe);
    apb(1, 8'h08, 32'h4);
    u_mcu.low_pulse(50);
    repeat (3) @(posedge pclk);
    chk("ov kept", 1, f_oe);
    chk("quick aux", 1, aux);
    apb(0, 8'h0C, 0);
    chk("quick regs", WSEL_OT, rd);
    // low held just past the band, beyond the full reset time.
    u_mcu.set(0, 6'h30);
    repeat (300) @(posedge pclk);
    chk("sleep aux", 0, aux);
    chk("sleep pump", 0, cpe);
    apb(0, 8'h0C, 0);
    chk("sleep apb", 1, err);
    repeat (220) @(posedge pclk);
    u_mcu.set(1, 6'h30);
    repeat (3) @(posedge pclk);
    chk("ov clr", 0, f_oe);
    apb(0, 8'h0C, 0);
    chk("full regs", 0, rd);
  endtask
  task automatic t_oc();
    u_mcu.set(0, 6'h22);
    apb(0, 8'h0C, 0);
    chk("quick apb", 0, err);
    chk("quick aux2", 1, aux);
    u_mcu.set(1, 6'h22);
    repeat (2) @(posedge pclk);
    oc <= 6'h20;
    @(posedge pclk);
    oc <= 6'h00;
    repeat (2) @(posedge pclk);
    chk("cl gate", 6'h02, gate_out);
    chk("cl fault", 0, f_oe);
    chk("cl warn", 1, w_oe);
    u_mcu.set(1, 6'h02);
    apb(1, 8'h08, 32'h10);
    chk("ctrl1 out", 32'h10, c1);
    u_mcu.set(1, 6'h22);
    oc <= 6'h20;
    @(posedge pclk);
    oc <= 6'h00;
    repeat (2) @(posedge pclk);
    chk("latch gate", 6'h02, gate_out);
    chk("latch fault", 1, f_oe);
    chk("latch warn", 1, w_oe);
    apb(0, 8'h00, 0);
    chk("latch st", 32'h420, rd);
    apb(1, 8'h08, 32'h14);
    apb(0, 8'h00, 0);
    chk("grst st", 0, rd);
    chk("grst fault", 0, f_oe);
  endtask
  task automatic t_puv();
    mon.power_supply_undervoltage <= 1;
    apb(0, 8'h08, 0);
    chk("puv apb", 1, err);
    chk("puv gate", 0, gate_out);
    chk("puv pulldown", 1, wpd);
    chk("puv fault", 1, f_oe);
    mon <= '0;
    apb(0, 8'h08, 0);
    chk("puv dflt", 0, rd);
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_start();
    t_faults();
    t_ov();
    t_oc();
    t_puv();
    finish_test();
  end
endmodule
